// [rtl/csc_core.sv]
// cpu flag word, core mode control and integer alu behind apb
// What this block does
// - bits 13/12 are sticky saturation flags for A/B until cleared
// - bit 11 ORs overflows; bit 10 ORs sticky flags, clear only
// - writes change sticky flags directly or by clearing bit 10
// - bit 9 shows DO loop active, bit 4 REPEAT loop active
// - half carry from bit 3 (byte) or bit 7 (word)
// - priority = {control bit 3, bits 7-5}; 1xxx or x111 masks users
// - priority field ignores writes while nesting block bit is set
// - bit 2 signed overflow, bit 3 negative result
// - zero flag cleared by non-zero result, never set by chain ops
// - carry from msb (bit 0 on shift right); on subtraction a 1 means no borrow
// - writing 1 to control bit 11 ends DO loop; reads zero
// - control bits 10-8 report DO loop nesting depth
// - control bit 4 selects super saturation
// - control bit 2 read only; frame/stack use base space when set
// - control bit 1 selects biased rounding
// - control bit 0 selects integer multiply
// - 16-bit alu adds, subtracts, shifts and logic on bytes or words
// - 17x17 multiplier covers signed, unsigned, mixed, literal, 8x8
// - divider 32/16 and 16/16 one cycle per bit; quotient w0 rem w1
`timescale 1ns/1ns
module csc_core (
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        clk_en,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic      [31:0] prdata,
	output logic             pslverr,
	// alu instruction
	input  wire logic        alu_go,
	input  wire logic [2:0]  alu_op,
	input  wire logic        alu_byte,
	input  wire logic        alu_chain_z,
	input  wire logic [15:0] alu_a,
	input  wire logic [15:0] alu_b,
	// multiply and divide instructions
	input  wire logic        mul_go,
	input  wire logic [2:0]  mul_mode,
	input  wire logic        div_go,
	input  wire logic        div_signed,
	input  wire logic        div_long,
	input  wire logic [31:0] div_dividend,
	input  wire logic [15:0] div_divisor,
	// accumulator and loop events
	input  wire logic        acc_a_ovf_in,
	input  wire logic        acc_b_ovf_in,
	input  wire logic        acc_a_sat_evt,
	input  wire logic        acc_b_sat_evt,
	input  wire logic        rep_active,
	input  wire logic        do_push,
	input  wire logic        do_pop,
	input  wire logic        frame_active,
	// control outputs
	output logic             user_irq_masked,
	output logic      [3:0]  cpu_priority,
	output logic             loop_early_exit,
	output logic      [1:0]  mul_sign_sel,
	output logic             acc_a_clip_en,
	output logic             acc_b_clip_en,
	output logic             store_clip_en,
	output logic             clip_level_sel,
	output logic             round_mode_sel,
	output logic             int_mode_sel,
	output logic             base_space_only,
	output logic             div_busy
);
	logic        acc_a_overflow;
	logic        acc_b_overflow;
	logic        acc_a_clip_sticky;
	logic        acc_b_clip_sticky;
	logic        half_carry;
	logic [2:0]  cpu_priority_low3;
	logic        neg_flag;
	logic        signed_wrap_flag;
	logic        zero_flag;
	logic        carry_flag;
	logic [15:0] core_mode_control;
	logic [2:0]  loop_nest_depth;
	logic [15:0] intr_ctrl1_reg;
	logic [15:0] work_reg_0;
	logic [15:0] work_reg_1;
	logic [15:0] alu_result;
	logic [31:0] mul_product;
	logic        div_done;
	logic [15:0] div_q;
	logic [15:0] div_r;
	logic        nesting_block;
	logic        wr;
	logic        wr_flag;
	logic        wr_core;
	logic [15:0] flag_word;
	logic [15:0] core_word;
	logic [16:0] next_sum;
	logic [15:0] next_res;
	logic        next_c;
	logic        next_dc;
	logic        next_ov;
	logic        next_n;
	logic        next_z;
	logic [15:0] b_eff;
	logic        mapped;

	assign pready = 1'b1;
	assign wr = psel & penable & pwrite & clk_en;
	assign wr_flag = wr && (paddr == csc_pkg::ADDR_FLAG_WORD);
	assign wr_core = wr && (paddr == csc_pkg::ADDR_CORE_MODE);
	assign nesting_block = intr_ctrl1_reg[csc_pkg::NESTING_BLOCK_BIT];

	assign flag_word = {acc_a_overflow, acc_b_overflow,
		acc_a_clip_sticky, acc_b_clip_sticky,
		acc_a_overflow | acc_b_overflow,
		acc_a_clip_sticky | acc_b_clip_sticky,
		loop_nest_depth != 3'h0, half_carry,
		cpu_priority_low3, rep_active, neg_flag,
		signed_wrap_flag, zero_flag, carry_flag};
	// early exit reads zero, depth and frame bits are live status
	assign core_word = {core_mode_control[15], 1'b0,
		core_mode_control[13:12], 1'b0, loop_nest_depth,
		core_mode_control[7:3], frame_active,
		core_mode_control[1:0]};

	// mode selects drive the dsp engine directly
	assign mul_sign_sel = core_mode_control[13:12];
	assign acc_a_clip_en = core_mode_control[csc_pkg::CM_ACC_A_CLIP_EN];
	assign acc_b_clip_en = core_mode_control[csc_pkg::CM_ACC_B_CLIP_EN];
	assign store_clip_en = core_mode_control[csc_pkg::CM_STORE_CLIP_EN];
	assign clip_level_sel = core_mode_control[csc_pkg::CM_CLIP_LEVEL_SEL];
	assign round_mode_sel = core_mode_control[csc_pkg::CM_RND];
	assign int_mode_sel = core_mode_control[csc_pkg::CM_IF];
	assign base_space_only = frame_active;
	assign cpu_priority = {core_mode_control[csc_pkg::CM_CPU_PRIORITY_TOP],
		cpu_priority_low3};
	assign user_irq_masked = core_mode_control[csc_pkg::CM_CPU_PRIORITY_TOP]
		| (cpu_priority_low3 == csc_pkg::IPL_ALL_MASKED);
	assign loop_early_exit = wr_core & pwdata[csc_pkg::CM_EDT];

	// alu datapath, byte ops keep the low eight bits; a byte right shift pulls in bit 8
	always_comb begin
		b_eff = (alu_op == csc_pkg::CSC_OP_SUB) ? ~alu_b : alu_b;
		next_sum = {1'b0, alu_a} + {1'b0, b_eff}
			+ {16'h0000, alu_op == csc_pkg::CSC_OP_SUB};
		next_res = next_sum[15:0];
		next_c = next_sum[16];
		next_dc = 1'b0;
		unique case (csc_pkg::csc_aluop_e'(alu_op))
			csc_pkg::CSC_OP_ADD, csc_pkg::CSC_OP_SUB: ;
			csc_pkg::CSC_OP_AND: next_res = alu_a & alu_b;
			csc_pkg::CSC_OP_OR:  next_res = alu_a | alu_b;
			csc_pkg::CSC_OP_XOR: next_res = alu_a ^ alu_b;
			csc_pkg::CSC_OP_SHL: next_res = alu_a << 1;
			csc_pkg::CSC_OP_SHR: next_res = alu_a >> 1;
			default: next_res = 16'h0000;
		endcase
		if (alu_byte) begin
			next_res = {8'h00, next_res[7:0]};
		end
		// carry out of the msb, or bit 0 on a right shift; on subtraction a 1 means no borrow
		if (alu_op == csc_pkg::CSC_OP_SHL) begin
			next_c = alu_byte ? alu_a[7] : alu_a[15];
		end else if (alu_op == csc_pkg::CSC_OP_SHR) begin
			next_c = alu_a[0];
		end else if (alu_byte) begin
			next_c = alu_a[8] ^ b_eff[8] ^ next_sum[8];
		end
		next_dc = alu_byte ? (alu_a[4] ^ b_eff[4] ^ next_sum[4])
			: (alu_a[8] ^ b_eff[8] ^ next_sum[8]);
		next_n = alu_byte ? next_res[7] : next_res[15];
		next_ov = alu_byte
			? (alu_a[7] == b_eff[7]) && (next_res[7] != alu_a[7])
			: (alu_a[15] == b_eff[15]) && (next_res[15] != alu_a[15]);
		next_z = next_res == 16'h0000;
	end

	// accumulator overflow follows the engine, sticky bits set over clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			acc_a_overflow <= 1'b0;
			acc_b_overflow <= 1'b0;
			acc_a_clip_sticky <= 1'b0;
			acc_b_clip_sticky <= 1'b0;
		end else if (clk_en) begin
			acc_a_overflow <= acc_a_ovf_in;
			acc_b_overflow <= acc_b_ovf_in;
			if (acc_a_sat_evt) begin
				acc_a_clip_sticky <= 1'b1;
			end else if (wr_flag) begin
				acc_a_clip_sticky <= pwdata[csc_pkg::FW_SA]
					& pwdata[csc_pkg::FW_SAB];
			end
			if (acc_b_sat_evt) begin
				acc_b_clip_sticky <= 1'b1;
			end else if (wr_flag) begin
				acc_b_clip_sticky <= pwdata[csc_pkg::FW_SB]
					& pwdata[csc_pkg::FW_SAB];
			end
		end
	end

	// arithmetic flags: alu update wins over a same-cycle software write
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			half_carry <= 1'b0;
			neg_flag <= 1'b0;
			signed_wrap_flag <= 1'b0;
			zero_flag <= 1'b0;
			carry_flag <= 1'b0;
			alu_result <= 16'h0000;
		end else if (clk_en) begin
			if (alu_go) begin
				alu_result <= next_res;
				half_carry <= next_dc;
				carry_flag <= next_c;
				neg_flag <= next_n;
				signed_wrap_flag <= next_ov;
				zero_flag <= alu_chain_z ? (zero_flag & next_z)
					: next_z;
			end else if (wr_flag) begin
				half_carry <= pwdata[csc_pkg::FW_DC];
				neg_flag <= pwdata[csc_pkg::FW_N];
				signed_wrap_flag <= pwdata[csc_pkg::FW_OV];
				zero_flag <= pwdata[csc_pkg::FW_Z];
				carry_flag <= pwdata[csc_pkg::FW_C];
			end
		end
	end

	// priority field
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cpu_priority_low3 <= 3'h0;
		end else if (clk_en && wr_flag && !nesting_block) begin
			cpu_priority_low3 <=
				pwdata[csc_pkg::FW_IPL_HI:csc_pkg::FW_IPL_LO];
		end
	end

	// core mode control writable bits
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			core_mode_control <= csc_pkg::CORE_MODE_RESET;
		end else if (wr_core) begin
			core_mode_control <= {pwdata[15], 1'b0, pwdata[13:12],
				4'h0, pwdata[7:3], 1'b0, pwdata[1:0]};
		end
	end

	// loop nesting depth saturates at seven
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			loop_nest_depth <= 3'h0;
		end else if (clk_en) begin
			if (do_push && !do_pop && loop_nest_depth != 3'h7) begin
				loop_nest_depth <= loop_nest_depth + 3'h1;
			end else if (do_pop && !do_push && loop_nest_depth != 3'h0) begin
				loop_nest_depth <= loop_nest_depth - 3'h1;
			end
		end
	end

	// interrupt control 1 (only the nesting block bit is kept)
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			intr_ctrl1_reg <= 16'h0000;
		end else if (wr && paddr == csc_pkg::ADDR_INTR_CTRL1) begin
			intr_ctrl1_reg <= {pwdata[csc_pkg::NESTING_BLOCK_BIT], 15'h0000};
		end
	end

	// working registers: divider results land here
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			work_reg_0 <= 16'h0000;
			work_reg_1 <= 16'h0000;
		end else if (clk_en) begin
			if (div_done) begin
				work_reg_0 <= div_q;
				work_reg_1 <= div_r;
			end else if (wr && paddr == csc_pkg::ADDR_WORK0) begin
				work_reg_0 <= pwdata[15:0];
			end else if (wr && paddr == csc_pkg::ADDR_WORK1) begin
				work_reg_1 <= pwdata[15:0];
			end
		end
	end

	csc_mul u_mul (
		.pclk    (pclk),
		.presetn (presetn),
		.clk_en  (clk_en),
		.start   (mul_go),
		.mode    (mul_mode),
		.opa     (alu_a),
		.opb     (alu_b),
		.product (mul_product)
	);

	// quotient lands one cycle after the internal done pulse
	logic div_done_raw;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_done <= 1'b0;
		end else if (clk_en) begin
			div_done <= div_done_raw;
		end
	end

	csc_div u_div (
		.pclk      (pclk),
		.presetn   (presetn),
		.clk_en    (clk_en),
		.start     (div_go),
		.is_signed (div_signed),
		.long_div  (div_long),
		.dividend  (div_dividend),
		.divisor   (div_divisor),
		.busy      (div_busy),
		.done      (div_done_raw),
		.quotient  (div_q),
		.remainder (div_r)
	);

	// apb read data, registered in the setup phase
	always_comb begin
		mapped = 1'b1;
		case (paddr)
			csc_pkg::ADDR_FLAG_WORD, csc_pkg::ADDR_CORE_MODE,
			csc_pkg::ADDR_INTR_CTRL1, csc_pkg::ADDR_MUL_LO,
			csc_pkg::ADDR_MUL_HI, csc_pkg::ADDR_WORK0,
			csc_pkg::ADDR_WORK1, csc_pkg::ADDR_ALU_RES,
			csc_pkg::ADDR_DIV_STAT: mapped = 1'b1;
			default: mapped = 1'b0;
		endcase
	end
	assign pslverr = psel & penable & ~mapped;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (clk_en && psel && !penable && !pwrite) begin
			unique case (paddr)
				csc_pkg::ADDR_FLAG_WORD: prdata <= {16'h0000, flag_word};
				csc_pkg::ADDR_CORE_MODE: prdata <= {16'h0000, core_word};
				csc_pkg::ADDR_INTR_CTRL1:
					prdata <= {16'h0000, intr_ctrl1_reg};
				csc_pkg::ADDR_MUL_LO:
					prdata <= {16'h0000, mul_product[15:0]};
				csc_pkg::ADDR_MUL_HI:
					prdata <= {16'h0000, mul_product[31:16]};
				csc_pkg::ADDR_WORK0: prdata <= {16'h0000, work_reg_0};
				csc_pkg::ADDR_WORK1: prdata <= {16'h0000, work_reg_1};
				csc_pkg::ADDR_ALU_RES: prdata <= {16'h0000, alu_result};
				csc_pkg::ADDR_DIV_STAT: prdata <= {31'h0000_0000, div_busy};
				default: prdata <= 32'h0000_0000;
			endcase
		end
	end
endmodule : csc_core

// [rtl/csc_div.sv]
// iterative divider, one quotient bit per cycle
`timescale 1ns/1ns
module csc_div (
	// clock
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        clk_en,
	// request
	input  wire logic        start,
	input  wire logic        is_signed,
	input  wire logic        long_div,
	input  wire logic [31:0] dividend,
	input  wire logic [15:0] divisor,
	// result
	output logic             busy,
	output logic             done,
	output logic      [15:0] quotient,
	output logic      [15:0] remainder
);
	logic [31:0] num;
	logic [15:0] den;
	logic [16:0] rem;
	logic [4:0]  step;
	logic        q_neg;
	logic        r_neg;
	logic [31:0] dvd_ext;
	logic [31:0] dvd_abs;
	logic [15:0] dsr_abs;
	logic [16:0] trial;

	always_comb begin
		dvd_ext = long_div ? dividend
			: {{16{is_signed & dividend[15]}}, dividend[15:0]};
		dvd_abs = (is_signed && dvd_ext[31]) ? -dvd_ext : dvd_ext;
		dsr_abs = (is_signed && divisor[15]) ? -divisor : divisor;
		trial = {rem[15:0], num[31]} - {1'b0, den};
	end

	// 16 steps for both sizes: the narrow dividend is widened first
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			num <= 32'h0000_0000;
			den <= 16'h0000;
			rem <= 17'h0_0000;
			step <= 5'h00;
			busy <= 1'b0;
			done <= 1'b0;
			q_neg <= 1'b0;
			r_neg <= 1'b0;
			quotient <= 16'h0000;
			remainder <= 16'h0000;
		end else if (clk_en) begin
			done <= 1'b0;
			if (start && !busy) begin
				num <= dvd_abs << 16;
				rem <= {1'b0, dvd_abs[31:16]};
				den <= dsr_abs;
				q_neg <= is_signed & (dvd_ext[31] ^ divisor[15]);
				r_neg <= is_signed & dvd_ext[31];
				step <= 5'(csc_pkg::DIV_STEPS);
				busy <= 1'b1;
			end else if (busy) begin
				if (!trial[16]) begin
					rem <= trial;
					num <= {num[30:0], 1'b1};
				end else begin
					rem <= {rem[15:0], num[31]};
					num <= {num[30:0], 1'b0};
				end
				step <= step - 5'h01;
				if (step == 5'h01) begin
					busy <= 1'b0;
					done <= 1'b1;
				end
			end else if (done) begin
				quotient <= q_neg ? -num[15:0] : num[15:0];
				remainder <= r_neg ? -rem[15:0] : rem[15:0];
			end
		end
	end
endmodule : csc_div

// [rtl/csc_mul.sv]
// 17x17 multiplier for the integer multiply modes
`timescale 1ns/1ns
module csc_mul (
	// clock
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        clk_en,
	// request
	input  wire logic        start,
	input  wire logic [2:0]  mode,
	input  wire logic [15:0] opa,
	input  wire logic [15:0] opb,
	// result
	output logic      [31:0] product
);
	logic        a_sx;
	logic        b_sx;
	logic [15:0] a_in;
	logic [15:0] b_in;
	logic signed [16:0] a17;
	logic signed [16:0] b17;
	logic signed [33:0] full;

	always_comb begin
		a_sx = 1'b0;
		b_sx = 1'b0;
		a_in = opa;
		b_in = opb;
		unique case (csc_pkg::csc_mulmode_e'(mode))
			csc_pkg::CSC_MUL_SS: begin
				a_sx = 1'b1;
				b_sx = 1'b1;
			end
			csc_pkg::CSC_MUL_UU: ;
			csc_pkg::CSC_MUL_SU: a_sx = 1'b1;
			csc_pkg::CSC_MUL_US: b_sx = 1'b1;
			csc_pkg::CSC_MUL_SLIT: begin
				a_sx = 1'b1;
				b_in = {11'h000, opb[4:0]};
			end
			csc_pkg::CSC_MUL_ULIT: b_in = {11'h000, opb[4:0]};
			csc_pkg::CSC_MUL_8X8: begin
				a_in = {8'h00, opa[7:0]};
				b_in = {8'h00, opb[7:0]};
			end
			default: ;
		endcase
		// one extra bit per side lets every sign mix share one array
		a17 = {a_sx & a_in[15], a_in};
		b17 = {b_sx & b_in[15], b_in};
		full = a17 * b17;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			product <= 32'h0000_0000;
		end else if (clk_en && start) begin
			product <= full[31:0];
		end
	end
endmodule : csc_mul

// [rtl/csc_pkg.sv]
// shared constants for the cpu status, core control and alu block
package csc_pkg;
	// apb byte offsets
	localparam logic [7:0] ADDR_FLAG_WORD  = 8'h00;
	localparam logic [7:0] ADDR_CORE_MODE  = 8'h04;
	localparam logic [7:0] ADDR_INTR_CTRL1 = 8'h08;
	localparam logic [7:0] ADDR_MUL_LO     = 8'h0C;
	localparam logic [7:0] ADDR_MUL_HI     = 8'h10;
	localparam logic [7:0] ADDR_WORK0      = 8'h14;
	localparam logic [7:0] ADDR_WORK1      = 8'h18;
	localparam logic [7:0] ADDR_ALU_RES    = 8'h1C;
	localparam logic [7:0] ADDR_DIV_STAT   = 8'h20;
	// flag word bit positions
	localparam int FW_OA  = 15;
	localparam int FW_OB  = 14;
	localparam int FW_SA  = 13;
	localparam int FW_SB  = 12;
	localparam int FW_OAB = 11;
	localparam int FW_SAB = 10;
	localparam int FW_DA  = 9;
	localparam int FW_DC  = 8;
	localparam int FW_IPL_HI = 7;
	localparam int FW_IPL_LO = 5;
	localparam int FW_RA  = 4;
	localparam int FW_N   = 3;
	localparam int FW_OV  = 2;
	localparam int FW_Z   = 1;
	localparam int FW_C   = 0;
	// core mode control bit positions
	localparam int CM_VAR = 15;
	localparam int CM_US_HI = 13;
	localparam int CM_US_LO = 12;
	localparam int CM_EDT = 11;
	localparam int CM_DL_HI = 10;
	localparam int CM_DL_LO = 8;
	localparam int CM_ACC_A_CLIP_EN = 7;
	localparam int CM_ACC_B_CLIP_EN = 6;
	localparam int CM_STORE_CLIP_EN = 5;
	localparam int CM_CLIP_LEVEL_SEL = 4;
	localparam int CM_CPU_PRIORITY_TOP = 3;
	localparam int CM_SFA = 2;
	localparam int CM_RND = 1;
	localparam int CM_IF = 0;
	localparam int NESTING_BLOCK_BIT = 15;
	// reset value: store clipping enabled only
	localparam logic [15:0] CORE_MODE_RESET = 16'h0020;
	localparam logic [2:0] IPL_ALL_MASKED = 3'h7;
	// multiply sign encodings
	localparam logic [1:0] US_SIGNED = 2'h0;
	localparam logic [1:0] US_UNSIGNED = 2'h1;
	localparam logic [1:0] US_MIXED = 2'h2;
	localparam int DIV_STEPS = 16;
	typedef enum logic [2:0] {
		CSC_OP_ADD, CSC_OP_SUB, CSC_OP_AND, CSC_OP_OR,
		CSC_OP_XOR, CSC_OP_SHL, CSC_OP_SHR
	} csc_aluop_e;
	typedef enum logic [2:0] {
		CSC_MUL_SS, CSC_MUL_UU, CSC_MUL_SU, CSC_MUL_US,
		CSC_MUL_SLIT, CSC_MUL_ULIT, CSC_MUL_8X8
	} csc_mulmode_e;
endpackage : csc_pkg

// [verif/csc_core_asserts.sv]
// concurrent checks on the ports of the status and core control block
`timescale 1ns/1ns
module csc_core_asserts (
	// clock and reset
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        clk_en,
	// apb
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	// instructions and outputs
	input wire logic        div_go,
	input wire logic        frame_active,
	input wire logic        user_irq_masked,
	input wire logic [3:0]  cpu_priority,
	input wire logic        loop_early_exit,
	input wire logic [1:0]  mul_sign_sel,
	input wire logic        acc_a_clip_en,
	input wire logic        acc_b_clip_en,
	input wire logic        store_clip_en,
	input wire logic        clip_level_sel,
	input wire logic        round_mode_sel,
	input wire logic        int_mode_sel,
	input wire logic        base_space_only,
	input wire logic        div_busy
);
	logic       wr_cm;
	logic [4:0] busy_cnt;
	assign wr_cm = psel && penable && pwrite && clk_en
		&& paddr == csc_pkg::ADDR_CORE_MODE;
	// counts only enabled cycles, since a frozen clock stalls the divider
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			busy_cnt <= 5'h00;
		else if (!div_busy)
			busy_cnt <= 5'h00;
		else if (clk_en)
			busy_cnt <= busy_cnt + 5'h01;
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	AST_MASKED: assert property (
		user_irq_masked == (cpu_priority[3] || cpu_priority[2:0] == 3'h7))
		else $error("mask wrong");
	AST_EARLY_EXIT: assert property (
		loop_early_exit == (wr_cm && pwdata[11]))
		else $error("exit wrong");
	AST_DIV_START: assert property (
		div_go && !div_busy && clk_en |=> div_busy)
		else $error("no start");
	AST_DIV_LEN: assert property (
		$fell(div_busy) |-> busy_cnt == 5'h10)
		else $error("div length");
	AST_SIGN_SEL: assert property (
		wr_cm |=> mul_sign_sel == $past(pwdata[13:12]))
		else $error("sign sel");
	AST_CLIP_EN: assert property (
		wr_cm |=> {acc_a_clip_en, acc_b_clip_en, store_clip_en}
			== $past(pwdata[7:5]))
		else $error("clip en");
	AST_MODE_SEL: assert property (
		wr_cm |=> {clip_level_sel, round_mode_sel, int_mode_sel}
			== {$past(pwdata[4]), $past(pwdata[1]), $past(pwdata[0])})
		else $error("mode sel");
	AST_BASE: assert property (
		frame_active |-> ##[0:1] base_space_only)
		else $error("base space");
endmodule : csc_core_asserts

bind csc_core csc_core_asserts i_csc_core_asserts (.pclk, .presetn,
	.clk_en, .psel, .penable, .pwrite, .paddr, .pwdata, .div_go,
	.frame_active, .user_irq_masked, .cpu_priority, .loop_early_exit,
	.mul_sign_sel, .acc_a_clip_en, .acc_b_clip_en, .store_clip_en,
	.clip_level_sel, .round_mode_sel, .int_mode_sel, .base_space_only,
	.div_busy);

// [verif/tb_csc_core.sv]
// self-checking bench for the status, core control and alu block
`timescale 1ns/1ns
module tb_csc_core;
	logic        pclk, presetn, clk_en, psel, penable, pwrite, pready;
	logic        pslverr, alu_go, alu_byte, alu_chain_z, mul_go, div_go;
	logic        div_signed, div_long, acc_a_ovf_in, acc_b_ovf_in;
	logic        acc_a_sat_evt, acc_b_sat_evt, rep_active, do_push, do_pop;
	logic        frame_active, user_irq_masked, loop_early_exit;
	logic        acc_a_clip_en, acc_b_clip_en, store_clip_en;
	logic        clip_level_sel, round_mode_sel, int_mode_sel;
	logic        base_space_only, div_busy, zf;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, div_dividend;
	logic [2:0]  alu_op, mul_mode;
	logic [15:0] alu_a, alu_b, div_divisor;
	logic [3:0]  cpu_priority;
	logic [1:0]  mul_sign_sel;
	logic [32:0] exq[$], mkq[$];
	logic [7:0]  adq[$];
	int          fails, compares;
	int          seed = 40301;

	csc_core i_csc_core (.*);

	initial pclk = 1'b0;
	always #20 pclk = ~pclk;

	task automatic report_and_stop();
		if (fails == 0 && compares > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : report_and_stop

	task automatic chk(input logic [7:0] a, input logic [32:0] s, e, m);
		compares++;
		if ((s & m) !== (e & m)) begin
			fails++;
			$display("BAD reg %h exp %h seen %h", a, e & m, s & m);
		end
	endtask : chk

	// read data is judged where the access phase completes
	always @(posedge pclk) begin
		if (psel && penable && !pwrite && pready === 1'b1) begin
			if (exq.size() == 0) begin
				fails++;
				$display("BAD read exp none seen %h", prdata);
			end else
				chk(adq.pop_front(), {pslverr, prdata}, exq.pop_front(),
					mkq.pop_front());
		end
	end

	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) begin
			fails++;
			report_and_stop();
		end
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : xfer

	task automatic rd(input logic [7:0] a, input logic [15:0] e, m);
		adq.push_back(a);
		exq.push_back({17'h00000, e});
		mkq.push_back({17'h1FFFF, m});
		xfer(1'b0, a, 32'h00000000);
	endtask : rd

	task automatic alu(input logic [2:0] op, input logic by, ch,
		input logic [15:0] a, b);
		logic [15:0] bb, r, fm;
		logic [16:0] s;
		logic [8:0]  s8;
		logic [4:0]  s4;
		logic        ci, ov, ng;
		ci = op == csc_pkg::CSC_OP_SUB;
		bb = ci ? ~b : b;
		s = {1'b0, a} + {1'b0, bb} + 17'(ci);
		s8 = {1'b0, a[7:0]} + {1'b0, bb[7:0]} + 9'(ci);
		s4 = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + 5'(ci);
		r = op == csc_pkg::CSC_OP_AND ? a & b
			: op == csc_pkg::CSC_OP_OR ? a | b
			: op == csc_pkg::CSC_OP_XOR ? a ^ b
			: op == csc_pkg::CSC_OP_SHL ? a << 1
			: op == csc_pkg::CSC_OP_SHR ? a >> 1 : s[15:0];
		if (by)
			r[15:8] = 8'h00;
		ng = by ? r[7] : r[15];
		ov = by ? a[7] == bb[7] && r[7] != a[7]
			: a[15] == bb[15] && r[15] != a[15];
		zf = (ch ? zf : 1'b1) & (r == 16'h0000);
		fm = op < 3'h2 ? 16'h010F : 16'h000A;
		@(posedge pclk);
		alu_go <= 1'b1;
		alu_op <= op;
		alu_byte <= by;
		alu_chain_z <= ch;
		alu_a <= a;
		alu_b <= b;
		@(posedge pclk);
		alu_go <= 1'b0;
		rd(csc_pkg::ADDR_FLAG_WORD, {7'h00, by ? s4[4] : s8[8], 4'h0, ng,
			ov, zf, by ? s8[8] : s[16]}, fm);
		rd(csc_pkg::ADDR_ALU_RES, r, by ? 16'h00FF : 16'hFFFF);
	endtask : alu

	task automatic mul(input logic [2:0] md, input logic [15:0] a, b);
		logic [31:0] x, y, p;
		x = md inside {3'h0, 3'h2, 3'h4} ? {{16{a[15]}}, a} : {16'h0, a};
		y = md inside {3'h0, 3'h3} ? {{16{b[15]}}, b} : {16'h0, b};
		if (md > 3'h3)
			y = {27'h0, b[4:0]};
		if (md == 3'h6)
			{x, y} = {24'h0, a[7:0], 24'h0, b[7:0]};
		p = x * y;
		@(posedge pclk);
		mul_go <= 1'b1;
		mul_mode <= md;
		alu_a <= a;
		alu_b <= b;
		@(posedge pclk);
		mul_go <= 1'b0;
		rd(csc_pkg::ADDR_MUL_LO, p[15:0], 16'hFFFF);
		rd(csc_pkg::ADDR_MUL_HI, p[31:16], 16'hFFFF);
	endtask : mul

	task automatic dv(input logic sg, lg, input logic [31:0] dd,
		input logic [15:0] ds);
		logic signed [31:0] x, y;
		int n;
		x = dd;
		y = sg ? {{16{ds[15]}}, ds} : {16'h0000, ds};
		@(posedge pclk);
		div_go <= 1'b1;
		div_signed <= sg;
		div_long <= lg;
		div_dividend <= dd;
		div_divisor <= ds;
		@(posedge pclk);
		div_go <= 1'b0;
		n = 0;
		do begin
			@(negedge pclk);
			n++;
		end while (div_busy === 1'b1 && n < 40);
		if (n >= 40) begin
			fails++;
			report_and_stop();
		end
		repeat (2) @(posedge pclk);
		rd(csc_pkg::ADDR_WORK0, 16'(x / y), 16'hFFFF);
		rd(csc_pkg::ADDR_WORK1, 16'(x % y), 16'hFFFF);
	endtask : dv

	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata, alu_go, alu_op} = '0;
		{alu_byte, alu_chain_z, alu_a, alu_b, mul_go, mul_mode, div_go} = '0;
		{div_signed, div_long, div_dividend, div_divisor, rep_active} = '0;
		{acc_a_ovf_in, acc_b_ovf_in, acc_a_sat_evt, acc_b_sat_evt} = '0;
		{do_push, do_pop, frame_active, zf, fails, compares} = '0;
		clk_en = 1'b1;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		rd(csc_pkg::ADDR_FLAG_WORD, 16'h0000, 16'hFFFF);
		rd(csc_pkg::ADDR_CORE_MODE, 16'h0020, 16'hFFFF);
		alu(csc_pkg::CSC_OP_ADD, 1'b0, 1'b0, 16'h7FFF, 16'h0001);
		alu(csc_pkg::CSC_OP_ADD, 1'b0, 1'b0, 16'hFFFF, 16'h0001);
		alu(csc_pkg::CSC_OP_SUB, 1'b1, 1'b1, 16'h1234, 16'h5634);
		alu(csc_pkg::CSC_OP_SUB, 1'b0, 1'b1, 16'h0001, 16'h0002);
		alu(csc_pkg::CSC_OP_ADD, 1'b0, 1'b1, 16'h0000, 16'h0000);
		for (int i = 0; i < 20; i++)
			alu(3'(i % 7), 1'(i / 5 % 2), 1'(i / 10),
				16'($random(seed)), 16'($random(seed)));
		for (int i = 0; i < 7; i++)
			mul(3'(i), 16'($random(seed)), 16'($random(seed)));
		dv(1'b0, 1'b0, 32'h000003E8, 16'h0007);
		dv(1'b1, 1'b1, 32'hFFFE7960, 16'h012C);
		dv(1'b1, 1'b0, 32'hFFFFFFF9, 16'h0002);
		dv(1'b0, 1'b1, 32'h00123456, 16'h1234);
		// overflow levels and sticky saturation
		acc_a_ovf_in <= 1'b1;
		rd(csc_pkg::ADDR_FLAG_WORD, 16'h8800, 16'hC800);
		acc_a_ovf_in <= 1'b0;
		acc_b_ovf_in <= 1'b1;
		acc_a_sat_evt <= 1'b1;
		acc_b_sat_evt <= 1'b1;
		@(posedge pclk);
		acc_a_sat_evt <= 1'b0;
		acc_b_sat_evt <= 1'b0;
		acc_b_ovf_in <= 1'b0;
		rd(csc_pkg::ADDR_FLAG_WORD, 16'h3400, 16'h3400);
		xfer(1'b1, csc_pkg::ADDR_FLAG_WORD, 32'h00002400);
		rd(csc_pkg::ADDR_FLAG_WORD, 16'h2400, 16'hFC00);
		xfer(1'b1, csc_pkg::ADDR_FLAG_WORD, 32'h00002000);
		rd(csc_pkg::ADDR_FLAG_WORD, 16'h0000, 16'h3400);
		// loop activity and nesting depth
		repeat (2) begin
			@(posedge pclk);
			do_push <= 1'b1;
			@(posedge pclk);
			do_push <= 1'b0;
		end
		rep_active <= 1'b1;
		frame_active <= 1'b1;
		rd(csc_pkg::ADDR_FLAG_WORD, 16'h0210, 16'h0210);
		rd(csc_pkg::ADDR_CORE_MODE, 16'h0204, 16'h0704);
		xfer(1'b1, csc_pkg::ADDR_CORE_MODE, 32'h0000FFFF);
		rd(csc_pkg::ADDR_CORE_MODE, 16'hB2F7, 16'hFFF7);
		for (int k = 0; k < 3; k++) begin
			xfer(1'b1, csc_pkg::ADDR_CORE_MODE, {18'h0, 2'(k), 12'h000});
			rd(csc_pkg::ADDR_CORE_MODE, {2'h0, 2'(k), 12'h0}, 16'hF0F3);
		end
		// priority field and its write lock
		xfer(1'b1, csc_pkg::ADDR_FLAG_WORD, 32'h000000E0);
		rd(csc_pkg::ADDR_FLAG_WORD, 16'h00E0, 16'h00E0);
		xfer(1'b1, csc_pkg::ADDR_INTR_CTRL1, 32'h00008000);
		xfer(1'b1, csc_pkg::ADDR_FLAG_WORD, 32'h00000000);
		rd(csc_pkg::ADDR_FLAG_WORD, 16'h00E0, 16'h00E0);
		xfer(1'b1, csc_pkg::ADDR_INTR_CTRL1, 32'h00000000);
		xfer(1'b1, csc_pkg::ADDR_FLAG_WORD, 32'h00000000);
		rd(csc_pkg::ADDR_FLAG_WORD, 16'h0000, 16'h00E0);
		adq.push_back(8'h40);
		exq.push_back({1'b1, 32'h00000000});
		mkq.push_back(33'h1FFFFFFFF);
		xfer(1'b0, 8'h40, 32'h00000000);
		repeat (4) @(posedge pclk);
		report_and_stop();
	end
endmodule : tb_csc_core
